// *** logic/rsrp_params.svh ***
`ifndef RSRP_PARAMS_SVH
`define RSRP_PARAMS_SVH

// ****************************************************************
// Mode register addresses
// ****************************************************************
`define RSRP_MA_BANK_MASK     8'h10
`define RSRP_MA_SEGMENT_MASK  8'h11

// ****************************************************************
// Reset values and field widths
// ****************************************************************
`define RSRP_MASK_RESET       8'h00
`define RSRP_NUM_BANKS        8
`define RSRP_NUM_SEGS         8

// ****************************************************************
// Timing in nanoseconds and derived cycles at 25 MHz
// ****************************************************************
`define RSRP_CLK_PERIOD_NS    40
`define RSRP_TCKESR_NS        15
`define RSRP_TXSR_NS          220
`define RSRP_TCPDED_CYC       2
`define RSRP_TCKESR_CYC       ((`RSRP_TCKESR_NS + `RSRP_CLK_PERIOD_NS - 1) / `RSRP_CLK_PERIOD_NS)
`define RSRP_TXSR_CYC         ((`RSRP_TXSR_NS + `RSRP_CLK_PERIOD_NS - 1) / `RSRP_CLK_PERIOD_NS)
// The load edge opens the exit interval and the done edge hands over to active.
`define RSRP_TXSR_LOAD        (`RSRP_TXSR_CYC - 2)
`define RSRP_SR_TIMER_CYC     16

// ****************************************************************
// Postponed refresh accounting limits
// ****************************************************************
`define RSRP_POSTPONE_MAX     8
`define RSRP_PB_PER_AB        8

`endif

// *** logic/rsrp_pkg.sv ***
`default_nettype none
package rsrp_pkg;

    // ****************************************************************
    // Decoded command-bus request
    // ****************************************************************
    typedef struct packed {
        logic       refresh_ab;
        logic       refresh_pb;
        logic       sr_entry;
        logic       mrw;
        logic [7:0] mrw_addr;
        logic [7:0] mrw_data;
    } rsrp_cmd_t;

    typedef enum logic [2:0] {
        RSRP_ACTIVE,
        RSRP_SR_CPDED,
        RSRP_SR_HOLD,
        RSRP_SR_EXIT
    } rsrp_state_t;

    // ****************************************************************
    // Status reported to the array
    // ****************************************************************
    typedef struct packed {
        logic       in_self_refresh;
        logic       rx_enabled;
        logic       clk_gated;
        logic       refresh_strobe;
        logic [2:0] refresh_bank;
        logic [2:0] refresh_segment;
    } rsrp_stat_t;

endpackage : rsrp_pkg
`default_nettype wire

// *** logic/rsrp_cmd_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsrp_params.svh"

module rsrp_cmd_decode (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             cke_i,
    input  wire logic             cs_n_i,
    input  wire logic [9:0]       ca_rise_i,
    input  wire logic [9:0]       ca_fall_i,
    output var  rsrp_pkg::rsrp_cmd_t cmd_o
);

    typedef struct packed {
        logic cke_prev;
    } rsrp_dec_state_t;

    rsrp_dec_state_t s_q;
    rsrp_dec_state_t s_d;
    logic            is_ref;

    always_comb begin
        s_d          = s_q;
        s_d.cke_prev = cke_i;
        is_ref       = !cs_n_i && !ca_rise_i[0] && !ca_rise_i[1] && ca_rise_i[2];
        cmd_o        = '0;
        cmd_o.sr_entry   = is_ref && !cke_i && s_q.cke_prev;
        cmd_o.refresh_ab = is_ref && cke_i && s_q.cke_prev && ca_rise_i[3];
        cmd_o.refresh_pb = is_ref && cke_i && s_q.cke_prev && !ca_rise_i[3];
        cmd_o.mrw        = !cs_n_i && cke_i && ca_rise_i[3:0] == 4'h0;
        cmd_o.mrw_addr   = {ca_rise_i[9:4], ca_fall_i[1:0]};
        cmd_o.mrw_data   = ca_fall_i[9:2];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            // CKE idles high, so a command at the first edge after reset is taken.
            s_q <= '{cke_prev: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

endmodule : rsrp_cmd_decode
`default_nettype wire

// *** logic/rsrp_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module rsrp_timer #(
    parameter int W = 16
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);

    typedef struct packed {
        logic [W-1:0] count;
    } rsrp_tmr_state_t;

    rsrp_tmr_state_t s_q;
    rsrp_tmr_state_t s_d;

    // ****************************************************************
    // Down counter; done is high while the count sits at zero.
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.count = value_i;
        end else if (s_q.count != '0) begin
            s_d.count = s_q.count - W'(1);
        end
        done_o = (s_q.count == '0);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : rsrp_timer
`default_nettype wire

// *** logic/rsrp_refresh_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsrp_params.svh"

// Contract
// - Postponed count frozen during self refresh.
// - Entry decoded on CKE falling with refresh code.
// - Receivers off after two-cycle CKE delay.
// - Ignore all inputs but CKE in self refresh.
// - Internal all-bank refresh within residency, timer-paced.
// - Exit interval counts from edge after CKE high.
// - Eight-bit bank mask written by mode write.
// - Masked bank gets no self refresh.
// - Masked segments skipped in unmasked banks.
// - Writes to reserved registers have no effect.
// - Per-bank counter resets on reset and exit.
module rsrp_refresh_ctrl #(
    parameter int NUM_BANKS    = `RSRP_NUM_BANKS,
    parameter int SR_TIMER_CYC = `RSRP_SR_TIMER_CYC
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              cke_i,
    input  wire logic              cs_n_i,
    input  wire logic [9:0]        ca_rise_i,
    input  wire logic [9:0]        ca_fall_i,
    output logic                   in_self_refresh_o,
    output logic                   rx_enabled_o,
    output logic                   clk_gated_o,
    output logic                   refresh_strobe_o,
    output logic                   refresh_all_o,
    output logic [2:0]             refresh_bank_o,
    output logic [2:0]             refresh_segment_o,
    output logic [2:0]             pb_bank_ptr_o,
    output logic signed [4:0]      postponed_o,
    output logic                   refresh_needed_o,
    output logic [7:0]             bank_mask_o,
    output logic [7:0]             segment_mask_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rsrp_pkg::rsrp_state_t st;
        logic [1:0]            cpded_cnt;
        logic [7:0]            bank_mask;
        logic [7:0]            seg_mask;
        logic [2:0]            pb_ptr;
        logic [2:0]            pb_round;
        logic signed [4:0]     postponed;
        logic                  need_refresh;
        logic                  first_done;
        logic [5:0]            sr_bank;
        logic [2:0]            sr_seg;
        logic                  strobe;
        logic                  strobe_all;
        logic [2:0]            out_bank;
        logic [2:0]            out_seg;
    } rsrp_ctl_state_t;

    rsrp_ctl_state_t     s_q;
    rsrp_ctl_state_t     s_d;
    rsrp_pkg::rsrp_cmd_t cmd;
    logic                tmr_load;
    logic [15:0]         tmr_value;
    logic                tmr_done;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // segment mask applied
    function automatic logic seg_refreshed(input logic [7:0] bmask,
                                           input logic [7:0] smask,
                                           input logic [2:0] bank,
                                           input logic [2:0] seg);
        seg_refreshed = !bmask[bank] && !smask[seg];
    endfunction : seg_refreshed

    // ****************************************************************
    // Submodules
    // ****************************************************************
    rsrp_cmd_decode rsrp_cmd_decode_i (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .cke_i     (cke_i),
        .cs_n_i    (cs_n_i),
        .ca_rise_i (ca_rise_i),
        .ca_fall_i (ca_fall_i),
        .cmd_o     (cmd)
    );

    rsrp_timer #(
        .W (16)
    ) rsrp_timer_i (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .load_i    (tmr_load),
        .value_i   (tmr_value),
        .done_o    (tmr_done)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d            = s_q;
        s_d.strobe     = 1'b0;
        s_d.strobe_all = 1'b0;
        tmr_load       = 1'b0;
        tmr_value      = '0;
        unique case (s_q.st)
            rsrp_pkg::RSRP_ACTIVE: begin
                if (cmd.mrw && cmd.mrw_addr == `RSRP_MA_BANK_MASK) begin
                    s_d.bank_mask = cmd.mrw_data;
                end
                if (cmd.mrw && cmd.mrw_addr == `RSRP_MA_SEGMENT_MASK) begin
                    s_d.seg_mask = cmd.mrw_data;
                end
                if (cmd.refresh_ab) begin
                    s_d.pb_ptr       = '0;
                    s_d.pb_round     = '0;
                    s_d.need_refresh = 1'b0;
                    s_d.postponed    = s_q.postponed - 5'sd1;
                    s_d.strobe       = 1'b1;
                    s_d.strobe_all   = 1'b1;
                end else if (cmd.refresh_pb) begin
                    s_d.strobe   = 1'b1;
                    s_d.out_bank = s_q.pb_ptr;
                    s_d.pb_ptr   = 3'(s_q.pb_ptr + 3'd1);
                    if (s_q.pb_round == 3'(`RSRP_PB_PER_AB - 1)) begin
                        s_d.pb_round     = '0;
                        s_d.need_refresh = 1'b0;
                        s_d.postponed    = s_q.postponed - 5'sd1;
                    end else begin
                        s_d.pb_round = 3'(s_q.pb_round + 3'd1);
                    end
                end else if (cmd.sr_entry) begin
                    s_d.st        = rsrp_pkg::RSRP_SR_CPDED;
                    s_d.cpded_cnt = 2'(`RSRP_TCPDED_CYC - 1);
                    s_d.first_done = 1'b0;
                    s_d.sr_bank   = '0;
                    s_d.sr_seg    = '0;
                    tmr_load      = 1'b1;
                    tmr_value     = 16'(`RSRP_TCKESR_CYC);
                end
            end
            rsrp_pkg::RSRP_SR_CPDED: begin
                if (s_q.cpded_cnt == '0) begin
                    s_d.st = rsrp_pkg::RSRP_SR_HOLD;
                end else begin
                    s_d.cpded_cnt = 2'(s_q.cpded_cnt - 2'd1);
                end
            end
            rsrp_pkg::RSRP_SR_HOLD: begin
                if (tmr_done) begin
                    s_d.first_done = 1'b1;
                    tmr_load       = 1'b1;
                    tmr_value      = 16'(SR_TIMER_CYC);
                    if (seg_refreshed(s_q.bank_mask, s_q.seg_mask,
                                      s_q.sr_bank[2:0], s_q.sr_seg)) begin
                        s_d.strobe   = 1'b1;
                        s_d.out_bank = s_q.sr_bank[2:0];
                        s_d.out_seg  = s_q.sr_seg;
                    end
                    s_d.sr_seg = 3'(s_q.sr_seg + 3'd1);
                    if (s_q.sr_seg == 3'(`RSRP_NUM_SEGS - 1)) begin
                        s_d.sr_bank = 6'((s_q.sr_bank + 6'd1) % NUM_BANKS);
                    end
                end
                if (cke_i) begin
                    s_d.st    = rsrp_pkg::RSRP_SR_EXIT;
                    tmr_load  = 1'b1;
                    // A shorter load lets the first command land right at tXSR end.
                    tmr_value = 16'(`RSRP_TXSR_LOAD);
                    s_d.pb_ptr   = '0;
                    s_d.pb_round = '0;
                    s_d.need_refresh = 1'b1;
                end
            end
            rsrp_pkg::RSRP_SR_EXIT: begin
                if (tmr_done) begin
                    s_d.st = rsrp_pkg::RSRP_ACTIVE;
                end
            end
            default: begin
                s_d.st = rsrp_pkg::RSRP_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            s_q           <= '0;
            s_q.st        <= rsrp_pkg::RSRP_ACTIVE;
            s_q.bank_mask <= `RSRP_MASK_RESET;
            s_q.seg_mask  <= `RSRP_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            in_self_refresh_o <= 1'b0;
            rx_enabled_o      <= 1'b1;
            clk_gated_o       <= 1'b0;
        end else begin
            in_self_refresh_o <= s_d.st != rsrp_pkg::RSRP_ACTIVE;
            rx_enabled_o      <= s_d.st != rsrp_pkg::RSRP_SR_HOLD;
            clk_gated_o       <= s_d.st == rsrp_pkg::RSRP_SR_HOLD && s_d.first_done;
        end
    end

    assign refresh_strobe_o  = s_q.strobe;
    assign refresh_all_o     = s_q.strobe_all;
    assign refresh_bank_o    = s_q.out_bank;
    assign refresh_segment_o = s_q.out_seg;
    assign pb_bank_ptr_o     = s_q.pb_ptr;
    assign postponed_o       = s_q.postponed;
    assign refresh_needed_o  = s_q.need_refresh;
    assign bank_mask_o       = s_q.bank_mask;
    assign segment_mask_o    = s_q.seg_mask;

endmodule : rsrp_refresh_ctrl
`default_nettype wire

// *** verif/rsrp_refresh_ctrl_props.sv ***
`timescale 1ns/10ps
`default_nettype none

module rsrp_refresh_ctrl_props (
    input wire logic              ref_clk_i,
    input wire logic              reset_n_i,
    input wire logic              cke_i,
    input wire logic              cs_n_i,
    input wire logic [9:0]        ca_rise_i,
    input wire logic [9:0]        ca_fall_i,
    input wire logic              in_self_refresh_o,
    input wire logic              rx_enabled_o,
    input wire logic              refresh_strobe_o,
    input wire logic [2:0]        refresh_bank_o,
    input wire logic [2:0]        refresh_segment_o,
    input wire logic [2:0]        pb_bank_ptr_o,
    input wire logic signed [4:0] postponed_o,
    input wire logic              refresh_needed_o,
    input wire logic [7:0]        bank_mask_o,
    input wire logic [7:0]        segment_mask_o
);
    // ********
    // Properties
    // ********
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_cmd(logic [3:0] c, logic [7:0] a, logic [7:0] m);
        rx_enabled_o && !in_self_refresh_o && cke_i && !cs_n_i && ca_rise_i[3:0] == c
        && (({ca_rise_i[9:4], ca_fall_i[1:0]} & m) == a);
    endsequence
    sequence s_exit;
        $rose(rx_enabled_o);
    endsequence

    property p_entry;
        rx_enabled_o && !in_self_refresh_o && $past(cke_i) && !cke_i && !cs_n_i
        && ca_rise_i[2:0] == 3'h4 |=> in_self_refresh_o;
    endproperty
    property p_rx_off;
        $rose(in_self_refresh_o) |-> rx_enabled_o [*2] ##1 !rx_enabled_o;
    endproperty
    property p_ignore;
        !rx_enabled_o |=> $stable(bank_mask_o) && $stable(segment_mask_o);
    endproperty
    property p_frozen;
        in_self_refresh_o |=> $stable(postponed_o);
    endproperty
    property p_bank_skip;
        refresh_strobe_o && in_self_refresh_o |-> !bank_mask_o[refresh_bank_o];
    endproperty
    property p_seg_skip;
        refresh_strobe_o && in_self_refresh_o |-> !segment_mask_o[refresh_segment_o];
    endproperty
    property p_ptr_sync;
        s_exit |-> pb_bank_ptr_o == 3'h0 && refresh_needed_o;
    endproperty
    property p_txsr;
        s_exit |-> in_self_refresh_o [*5] ##1 !in_self_refresh_o;
    endproperty
    property p_pb;
        s_cmd(4'h4, 8'h00, 8'h00) |=> refresh_strobe_o && refresh_bank_o == $past(pb_bank_ptr_o)
        && pb_bank_ptr_o == $past(pb_bank_ptr_o) + 3'h1;
    endproperty
    property p_mrw;
        s_cmd(4'h0, 8'h10, 8'hff) |=> bank_mask_o == $past(ca_fall_i[9:2]);
    endproperty
    property p_reserved;
        s_cmd(4'h0, 8'h12, 8'hff) |=> $stable(bank_mask_o) && $stable(segment_mask_o);
    endproperty

    a_entry: assert property (p_entry) else $error("entry not taken");
    a_rx_off: assert property (p_rx_off) else $error("receiver cut-off timing");
    a_ignore: assert property (p_ignore) else $error("input taken in hold");
    a_frozen: assert property (p_frozen) else $error("count moved");
    a_bank_skip: assert property (p_bank_skip) else $error("masked bank hit");
    a_seg_skip: assert property (p_seg_skip) else $error("masked segment hit");
    a_ptr_sync: assert property (p_ptr_sync) else $error("pointer not cleared");
    a_txsr: assert property (p_txsr) else $error("exit interval length");
    a_pb: assert property (p_pb) else $error("bank refresh target");
    a_mrw: assert property (p_mrw) else $error("bank mask write");
    a_reserved: assert property (p_reserved) else $error("reserved write took effect");
endmodule : rsrp_refresh_ctrl_props

`default_nettype wire

// *** verif/rsrp_ctl_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module rsrp_ctl_model (
    input  wire logic       ref_clk_i,
    output var  logic       cke_o,
    output var  logic       cs_n_o,
    output var  logic [9:0] ca_rise_o,
    output var  logic [9:0] ca_fall_o
);
    // ********
    // Command driver
    // ********
    initial begin
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        ca_rise_o = 10'h2aa;
        ca_fall_o = 10'h155;
    end

    // Deselected lines toggle, so a stale value never passes for a command.
    task automatic put(input logic k, input logic c, input logic [9:0] r, input logic [9:0] f);
        cke_o = k;
        cs_n_o = c;
        ca_rise_o = c ? ~ca_rise_o : r;
        ca_fall_o = c ? ~ca_fall_o : f;
        @(posedge ref_clk_i);
        #1;
    endtask : put

    task automatic nop(input logic k, input int n);
        repeat (n) put(k, 1'b0, 10'h3ff, ~ca_fall_o);
    endtask : nop

    task automatic refresh(input logic all);
        put(1'b1, 1'b0, {6'h15, all, 3'h4}, 10'h0c3);
    endtask : refresh

    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, 1'b0, {a[7:2], 4'h0}, {d, a[1:0]});
    endtask : mrw

    task automatic enter();
        put(1'b0, 1'b0, 10'h004, 10'h0c3);
        nop(1'b0, 2);
    endtask : enter

    task automatic stay();
        put(1'b0, 1'b1, 10'h000, 10'h000);
    endtask : stay
endmodule : rsrp_ctl_model

`default_nettype wire

// *** verif/rsrp_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsrp_params.svh"

module rsrp_test;
    logic              ref_clk_i;
    logic              reset_n_i;
    logic              cke_i;
    logic              cs_n_i;
    logic [9:0]        ca_rise_i;
    logic [9:0]        ca_fall_i;
    logic              in_self_refresh_o;
    logic              rx_enabled_o;
    logic              clk_gated_o;
    logic              refresh_strobe_o;
    logic              refresh_all_o;
    logic [2:0]        refresh_bank_o;
    logic [2:0]        refresh_segment_o;
    logic [2:0]        pb_bank_ptr_o;
    logic signed [4:0] postponed_o;
    logic              refresh_needed_o;
    logic [7:0]        bank_mask_o;
    logic [7:0]        segment_mask_o;
    int                mismatches;
    int                comparisons;

    // A timer load of 1, a refresh every two cycles, lets one self refresh walk past a masked bank.
    rsrp_refresh_ctrl #(
        .SR_TIMER_CYC (1)
    ) rsrp_refresh_ctrl_i (
        .ref_clk_i         (ref_clk_i),
        .reset_n_i         (reset_n_i),
        .cke_i             (cke_i),
        .cs_n_i            (cs_n_i),
        .ca_rise_i         (ca_rise_i),
        .ca_fall_i         (ca_fall_i),
        .in_self_refresh_o (in_self_refresh_o),
        .rx_enabled_o      (rx_enabled_o),
        .clk_gated_o       (clk_gated_o),
        .refresh_strobe_o  (refresh_strobe_o),
        .refresh_all_o     (refresh_all_o),
        .refresh_bank_o    (refresh_bank_o),
        .refresh_segment_o (refresh_segment_o),
        .pb_bank_ptr_o     (pb_bank_ptr_o),
        .postponed_o       (postponed_o),
        .refresh_needed_o  (refresh_needed_o),
        .bank_mask_o       (bank_mask_o),
        .segment_mask_o    (segment_mask_o)
    );
    rsrp_ctl_model rsrp_ctl_model_i (
        .ref_clk_i (ref_clk_i),
        .cke_o     (cke_i),
        .cs_n_o    (cs_n_i),
        .ca_rise_o (ca_rise_i),
        .ca_fall_o (ca_fall_i)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic t_per_bank();
        for (int b = 0; b < 8; b++) begin
            rsrp_ctl_model_i.refresh(1'b0);
            check({refresh_strobe_o, refresh_all_o, 3'h0, refresh_bank_o}, {5'h10, 3'(b)});
            check(8'(pb_bank_ptr_o), 8'((b + 1) % 8));
        end
        rsrp_ctl_model_i.refresh(1'b1);
        check({6'h0, refresh_strobe_o, refresh_all_o}, 8'h03);
    endtask : t_per_bank

    task automatic t_masks();
        rsrp_ctl_model_i.mrw(`RSRP_MA_BANK_MASK, 8'h82);
        rsrp_ctl_model_i.mrw(`RSRP_MA_SEGMENT_MASK, 8'h84);
        rsrp_ctl_model_i.mrw(8'h12, 8'hff);
        rsrp_ctl_model_i.mrw(8'h0c, 8'hff);
        check(bank_mask_o, 8'h82);
        check(segment_mask_o, 8'h84);
    endtask : t_masks

    task automatic t_self_refresh();
        logic signed [4:0] held;
        int                hits;
        int                wait_n;
        hits = 0;
        wait_n = 0;
        repeat (3) rsrp_ctl_model_i.refresh(1'b0);
        held = postponed_o;
        rsrp_ctl_model_i.enter();
        check(8'(in_self_refresh_o), 8'h01);
        rsrp_ctl_model_i.put(1'b0, 1'b0, 10'h040, 10'h000);
        check(8'(rx_enabled_o), 8'h00);
        check(8'(clk_gated_o), 8'h01);
        repeat (40) begin
            if (refresh_strobe_o === 1'b1) begin
                hits++;
                check(8'(bank_mask_o[refresh_bank_o]), 8'h00);
                check(8'(segment_mask_o[refresh_segment_o]), 8'h00);
            end
            rsrp_ctl_model_i.stay();
        end
        check(8'(hits), 8'h09);
        check(bank_mask_o, 8'h82);
        check(8'(postponed_o), 8'(held));
        rsrp_ctl_model_i.nop(1'b1, 1);
        check({rx_enabled_o, refresh_needed_o, 3'h0, pb_bank_ptr_o}, 8'hc0);
        while (in_self_refresh_o !== 1'b0 && wait_n < 20) begin
            rsrp_ctl_model_i.nop(1'b1, 1);
            wait_n++;
        end
        check(8'(wait_n + 1), 8'(`RSRP_TXSR_CYC));
        rsrp_ctl_model_i.refresh(1'b1);
        rsrp_ctl_model_i.nop(1'b1, 1);
        check(8'(refresh_needed_o), 8'h00);
    endtask : t_self_refresh

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // A hang ends the run well past the fewer than one hundred cycles the tests need.
    initial begin
        repeat (2000) @(posedge ref_clk_i);
        mismatches++;
        print_verdict();
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        reset_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        reset_n_i = 1'b1;
        check({bank_mask_o, segment_mask_o} == 16'h0, 8'h01);
        check({rx_enabled_o, 4'h0, pb_bank_ptr_o}, 8'h80);
        t_per_bank();
        t_masks();
        t_self_refresh();
        print_verdict();
    end
endmodule : rsrp_test

bind rsrp_refresh_ctrl rsrp_refresh_ctrl_props rsrp_refresh_ctrl_props_i (
    .ref_clk_i         (ref_clk_i),
    .reset_n_i         (reset_n_i),
    .cke_i             (cke_i),
    .cs_n_i            (cs_n_i),
    .ca_rise_i         (ca_rise_i),
    .ca_fall_i         (ca_fall_i),
    .in_self_refresh_o (in_self_refresh_o),
    .rx_enabled_o      (rx_enabled_o),
    .refresh_strobe_o  (refresh_strobe_o),
    .refresh_bank_o    (refresh_bank_o),
    .refresh_segment_o (refresh_segment_o),
    .pb_bank_ptr_o     (pb_bank_ptr_o),
    .postponed_o       (postponed_o),
    .refresh_needed_o  (refresh_needed_o),
    .bank_mask_o       (bank_mask_o),
    .segment_mask_o    (segment_mask_o)
);

`default_nettype wire
